// >>> verilog/wp_pkg.sv
// Constants and types shared by the write-protect controller files.
// Assumes a 100 MHz system clock that oversamples the two-wire bus pins.
package wp_pkg;

  // ************************************************************
  // Bus command encoding
  // ************************************************************
  localparam logic [3:0] ARRAY_NIBBLE = 4'hA;
  localparam logic [3:0] PROT_NIBBLE = 4'h6;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [7:0] IDLE_BYTE = 8'hFF;
  localparam logic [7:0] UPPER_HALF_START = 8'h80;
  localparam logic [7:0] ARRAY_LAST_ADDR = 8'hFF;
  localparam int PAGE_LSB_W = 4;

  // ************************************************************
  // Register port map
  // ************************************************************
  localparam logic [3:0] REG_CTRL_OFS = 4'h0;
  localparam logic [3:0] REG_STATUS_OFS = 4'h4;
  localparam logic [3:0] REG_ADDR_OFS = 4'h8;
  localparam int CTRL_RESPOND_BIT = 0;
  localparam logic [7:0] CTRL_RESET = 8'h01;
  localparam int ST_PERM_BIT = 0;
  localparam int ST_REV_BIT = 1;
  localparam int ST_WP_BIT = 2;
  localparam int ST_BUSY_BIT = 3;
  localparam int ST_REFUSED_BIT = 4;
  localparam int ST_HV_BIT = 5;

  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic [4:0] {
    CMD_NONE = 5'h01,
    CMD_ARRAY = 5'h02,
    CMD_PERM = 5'h04,
    CMD_REV = 5'h08,
    CMD_REV_CLR = 5'h10
  } cmd_kind_t;

  typedef enum logic [8:0] {
    ST_IDLE = 9'h001,
    ST_DEV = 9'h002,
    ST_DEV_ACK = 9'h004,
    ST_WORD = 9'h008,
    ST_WORD_ACK = 9'h010,
    ST_DATA = 9'h020,
    ST_DATA_ACK = 9'h040,
    ST_TX = 9'h080,
    ST_MACK = 9'h100
  } bus_state_t;

  typedef struct packed {
    logic ack;
    logic commit;
    logic set_perm;
    logic set_rev;
    logic clr_rev;
  } verdict_t;

  typedef struct packed {
    logic scl;
    logic sda;
    logic wp;
    logic hv;
    logic [2:0] pins;
  } pins_t;

endpackage

// >>> verilog/pin_sync.sv
// Two-stage synchroniser for a group of asynchronous pins.
// Assumes the pins are quasi-static against the sampling clock.
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 7,
  parameter logic [WIDTH-1:0] RESET_VAL = '1
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_reg;

  if (WIDTH < 1) begin : g_bad_width
    $error("pin_sync needs at least one bit");
  end

  // ************************************************************
  // One pair of flops per pin
  // ************************************************************
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    always_ff @(posedge clk_in) begin
      if (!rst_b_in) begin
        meta_reg[i] <= RESET_VAL[i];
        sync_out[i] <= RESET_VAL[i];
      end else begin
        meta_reg[i] <= async_in[i];
        sync_out[i] <= meta_reg[i];
      end
    end
  end

endmodule

// >>> verilog/wp_decide.sv
// Protection verdict for one decoded command: acknowledge and effects.
// Assumes flags and pin levels are stable for the cycle they are read.
`timescale 1ns/1ps
module wp_decide (
  input wire wp_pkg::cmd_kind_t kind_in,
  input wire logic rw_in,
  input wire logic wp_in,
  input wire logic perm_in,
  input wire logic rev_in,
  input wire logic [7:0] word_addr_in,
  output wp_pkg::verdict_t verdict_out
);

  function automatic logic in_lower_half(input logic [7:0] a);
    in_lower_half = (a < wp_pkg::UPPER_HALF_START);
  endfunction

  always_comb begin
    verdict_out = '0;
    case (kind_in)
      wp_pkg::CMD_ARRAY: begin
        verdict_out.ack = 1'b1;
        // Pin high blocks all; flags guard only the lower half
        verdict_out.commit = !rw_in && !wp_in &&
          !((perm_in || rev_in) && in_lower_half(word_addr_in));
      end
      wp_pkg::CMD_PERM: begin
        verdict_out.ack = !perm_in;
        verdict_out.set_perm = !rw_in && !perm_in && !wp_in;
      end
      wp_pkg::CMD_REV: begin
        verdict_out.ack = !rev_in;
        verdict_out.set_rev = !rw_in && !rev_in && !wp_in;
      end
      wp_pkg::CMD_REV_CLR: begin
        verdict_out.ack = !perm_in;
        verdict_out.clr_rev = !perm_in && !wp_in;
      end
      default: begin
        verdict_out = '0;
      end
    endcase
  end

endmodule

// >>> verilog/eeprom_write_protect_control.sv
// Two-wire slave front end with write-protect decisions for a 256x8 array.
// Assumes an external array that takes write pulses and supplies read data
// on the system clock, and a pull-down that makes a floating WP read low.
//
// Behaviour
// - Flags set, pin low: only 80H-FFH written
// - No flags, pin low: write anywhere
// - Floating protect pin acts as grounded
// - Permanent flag set: permanent commands unacknowledged
// - Permanent clear: status read acknowledged, data meaningless
// - Pin low, permanent clear: set acknowledged, sticks
// - Reversible set: its read and set unacknowledged
// - Reversible clear: status read acknowledged, data meaningless
// - Pin low, reversible clear: set acknowledged
// - Permanent set: clear command refused, no change
// - Pin low, permanent clear: clear acknowledged, clears
// - Pin high: array acknowledged, writes blocked
// - Pin high: flag commands acknowledged, no change
// - Nibbles 1010 array, 0110 protect, then address, R/W
// - Reversible set/clear use high-voltage address pin
// - Software protection covers 00H-7FH only
// - Protected writes acknowledged but not stored
//
// Local design decisions: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
module eeprom_write_protect_control (
  input wire logic SYS_CLK_IN,
  input wire logic RST_B_IN,
  input wire logic SCL_IN,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE_OUT,
  input wire logic WP_IN,
  input wire logic ADDR_PIN_ZERO_IN,
  input wire logic ADDR_PIN_ONE_IN,
  input wire logic ADDR_PIN_TWO_IN,
  input wire logic HIGH_VOLTAGE_LEVEL_IN,
  output logic ARRAY_WR_OUT,
  output logic [7:0] ARRAY_ADDR_OUT,
  output logic [7:0] ARRAY_WDATA_OUT,
  output logic ARRAY_RD_OUT,
  input wire logic [7:0] ARRAY_RDATA_IN,
  output logic PERMANENT_PROTECT_FLAG_OUT,
  output logic REVERSIBLE_PROTECT_FLAG_OUT,
  input wire logic [3:0] REG_ADDR_IN,
  input wire logic [7:0] REG_WDATA_IN,
  input wire logic REG_WR_IN,
  input wire logic REG_RD_IN,
  output logic [7:0] REG_RDATA_OUT
);

  // ************************************************************
  // Pin synchronisation and bus events
  // ************************************************************
  wp_pkg::pins_t pins_raw;
  wp_pkg::pins_t pins_s;
  logic scl_prev_reg;
  logic sda_prev_reg;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;

  // Floating WP is pulled low outside, so a low level covers both cases
  assign pins_raw = '{scl: SCL_IN, sda: SDA_IN, wp: WP_IN,
    hv: HIGH_VOLTAGE_LEVEL_IN,
    pins: {ADDR_PIN_TWO_IN, ADDR_PIN_ONE_IN, ADDR_PIN_ZERO_IN}};

  pin_sync #(
    .WIDTH($bits(wp_pkg::pins_t)),
    .RESET_VAL({1'b1, 1'b1, 1'b0, 1'b0, 3'h0})
  ) u_sync (
    .clk_in(SYS_CLK_IN),
    .rst_b_in(RST_B_IN),
    .async_in(pins_raw),
    .sync_out(pins_s)
  );

  always_ff @(posedge SYS_CLK_IN) begin
    if (!RST_B_IN) begin
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end else begin
      scl_prev_reg <= pins_s.scl;
      sda_prev_reg <= pins_s.sda;
    end
  end

  assign scl_rise = pins_s.scl && !scl_prev_reg;
  assign scl_fall = !pins_s.scl && scl_prev_reg;
  assign start_seen = pins_s.scl && scl_prev_reg && sda_prev_reg &&
    !pins_s.sda;
  assign stop_seen = pins_s.scl && scl_prev_reg && !sda_prev_reg &&
    pins_s.sda;

  // ************************************************************
  // Command classification
  // ************************************************************
  function automatic wp_pkg::cmd_kind_t classify(input logic [7:0] b,
      input logic [2:0] pins, input logic hv);
    classify = wp_pkg::CMD_NONE;
    if (b[7:4] == wp_pkg::ARRAY_NIBBLE && b[3:1] == pins) begin
      classify = wp_pkg::CMD_ARRAY;
    end else if (b[7:4] == wp_pkg::PROT_NIBBLE) begin
      // High voltage on pin zero selects the reversible flag commands
      if (hv) begin
        if (!pins[2] && b[3:1] == {1'b0, pins[1], 1'b1}) begin
          if (!pins[1]) begin
            classify = wp_pkg::CMD_REV;
          end else if (!b[0]) begin
            classify = wp_pkg::CMD_REV_CLR;
          end
        end
      end else if (b[3:1] == pins) begin
        classify = wp_pkg::CMD_PERM;
      end
    end
  endfunction

  // ************************************************************
  // State
  // ************************************************************
  wp_pkg::bus_state_t state_reg;
  logic [3:0] bit_cnt_reg;
  logic [7:0] shift_reg;
  logic [7:0] tx_reg;
  logic master_ack_reg;
  wp_pkg::cmd_kind_t kind_reg;
  logic rw_reg;
  logic [7:0] word_addr_reg;
  logic data_seen_reg;
  logic pend_set_perm_reg;
  logic pend_set_rev_reg;
  logic pend_clr_rev_reg;
  logic refused_reg;
  logic [7:0] ctrl_reg;
  // Nonvolatile: reset never touches them; power-up value is erased
  logic perm_flag_reg = 1'b0;
  logic rev_flag_reg = 1'b0;

  wp_pkg::cmd_kind_t kind_sel;
  logic rw_sel;
  wp_pkg::verdict_t verdict;
  logic respond;
  logic byte_done;

  assign respond = ctrl_reg[wp_pkg::CTRL_RESPOND_BIT];
  assign byte_done = scl_fall && bit_cnt_reg == wp_pkg::BYTE_BITS;
  // The address byte is judged on the shift register before it is kept
  assign kind_sel = (state_reg == wp_pkg::ST_DEV) ?
    classify(shift_reg, pins_s.pins, pins_s.hv) : kind_reg;
  assign rw_sel = (state_reg == wp_pkg::ST_DEV) ? shift_reg[0] : rw_reg;

  wp_decide u_decide (
    .kind_in(kind_sel),
    .rw_in(rw_sel),
    .wp_in(pins_s.wp),
    .perm_in(perm_flag_reg),
    .rev_in(rev_flag_reg),
    .word_addr_in(word_addr_reg),
    .verdict_out(verdict)
  );

  // ************************************************************
  // Bus sequencing
  // ************************************************************
  always_ff @(posedge SYS_CLK_IN) begin
    if (!RST_B_IN) begin
      state_reg <= wp_pkg::ST_IDLE;
      bit_cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      tx_reg <= wp_pkg::IDLE_BYTE;
      master_ack_reg <= 1'b0;
      kind_reg <= wp_pkg::CMD_NONE;
      rw_reg <= 1'b0;
      data_seen_reg <= 1'b0;
      SDA_OE_OUT <= 1'b0;
    end else if (start_seen) begin
      state_reg <= wp_pkg::ST_DEV;
      bit_cnt_reg <= 4'h0;
      data_seen_reg <= 1'b0;
      SDA_OE_OUT <= 1'b0;
    end else if (stop_seen) begin
      state_reg <= wp_pkg::ST_IDLE;
      bit_cnt_reg <= 4'h0;
      SDA_OE_OUT <= 1'b0;
    end else begin
      case (state_reg)
        wp_pkg::ST_DEV, wp_pkg::ST_WORD, wp_pkg::ST_DATA: begin
          if (scl_rise) begin
            shift_reg <= {shift_reg[6:0], pins_s.sda};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end else if (byte_done) begin
            bit_cnt_reg <= 4'h0;
            if (state_reg == wp_pkg::ST_DEV) begin
              kind_reg <= kind_sel;
              rw_reg <= rw_sel;
            end
            if (respond && (state_reg != wp_pkg::ST_DEV || verdict.ack)) begin
              SDA_OE_OUT <= 1'b1;
              state_reg <= (state_reg == wp_pkg::ST_DEV) ?
                wp_pkg::ST_DEV_ACK : (state_reg == wp_pkg::ST_WORD) ?
                wp_pkg::ST_WORD_ACK : wp_pkg::ST_DATA_ACK;
              if (state_reg == wp_pkg::ST_DATA) begin
                data_seen_reg <= 1'b1;
              end
            end else begin
              state_reg <= wp_pkg::ST_IDLE;
            end
          end
        end
        wp_pkg::ST_DEV_ACK: begin
          if (scl_fall) begin
            if (rw_reg) begin
              // Flag status reads return released bits, of no meaning
              tx_reg <= (kind_reg == wp_pkg::CMD_ARRAY) ?
                ARRAY_RDATA_IN : wp_pkg::IDLE_BYTE;
              SDA_OE_OUT <= (kind_reg == wp_pkg::CMD_ARRAY) ?
                !ARRAY_RDATA_IN[7] : 1'b0;
              bit_cnt_reg <= 4'h1;
              state_reg <= wp_pkg::ST_TX;
            end else begin
              SDA_OE_OUT <= 1'b0;
              state_reg <= wp_pkg::ST_WORD;
            end
          end
        end
        wp_pkg::ST_WORD_ACK, wp_pkg::ST_DATA_ACK: begin
          if (scl_fall) begin
            SDA_OE_OUT <= 1'b0;
            state_reg <= wp_pkg::ST_DATA;
          end
        end
        wp_pkg::ST_TX: begin
          if (scl_fall) begin
            if (bit_cnt_reg == wp_pkg::BYTE_BITS) begin
              SDA_OE_OUT <= 1'b0;
              state_reg <= wp_pkg::ST_MACK;
            end else begin
              SDA_OE_OUT <= !tx_reg[3'h7 - bit_cnt_reg[2:0]];
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end
          end
        end
        wp_pkg::ST_MACK: begin
          if (scl_rise) begin
            master_ack_reg <= !pins_s.sda;
          end else if (scl_fall) begin
            if (master_ack_reg) begin
              tx_reg <= (kind_reg == wp_pkg::CMD_ARRAY) ?
                ARRAY_RDATA_IN : wp_pkg::IDLE_BYTE;
              SDA_OE_OUT <= (kind_reg == wp_pkg::CMD_ARRAY) ?
                !ARRAY_RDATA_IN[7] : 1'b0;
              bit_cnt_reg <= 4'h1;
              state_reg <= wp_pkg::ST_TX;
            end else begin
              state_reg <= wp_pkg::ST_IDLE;
            end
          end
        end
        default: begin
          SDA_OE_OUT <= 1'b0;
          bit_cnt_reg <= 4'h0;
        end
      endcase
    end
  end

  // Only ever pulls low; the enable carries the bit
  always_ff @(posedge SYS_CLK_IN) begin
    SDA_OUT <= 1'b0;
  end

  // ************************************************************
  // Array address and write commit
  // ************************************************************
  logic data_byte_done;
  logic word_byte_done;

  assign data_byte_done = state_reg == wp_pkg::ST_DATA && byte_done &&
    respond && !start_seen && !stop_seen;
  assign word_byte_done = state_reg == wp_pkg::ST_WORD && byte_done &&
    respond && !start_seen && !stop_seen;

  always_ff @(posedge SYS_CLK_IN) begin
    if (!RST_B_IN) begin
      word_addr_reg <= 8'h00;
      ARRAY_WR_OUT <= 1'b0;
      ARRAY_WDATA_OUT <= 8'h00;
      refused_reg <= 1'b0;
    end else begin
      ARRAY_WR_OUT <= 1'b0;
      if (word_byte_done && kind_reg == wp_pkg::CMD_ARRAY) begin
        word_addr_reg <= shift_reg;
      end else if (data_byte_done && kind_reg == wp_pkg::CMD_ARRAY) begin
        // Protected bytes are acknowledged and dropped
        ARRAY_WR_OUT <= verdict.commit;
        ARRAY_WDATA_OUT <= shift_reg;
        refused_reg <= !verdict.commit;
        // Roll over inside the page
        word_addr_reg[wp_pkg::PAGE_LSB_W-1:0] <=
          word_addr_reg[wp_pkg::PAGE_LSB_W-1:0] + 1'b1;
      end else if (ARRAY_RD_OUT) begin
        word_addr_reg <= (word_addr_reg == wp_pkg::ARRAY_LAST_ADDR) ?
          8'h00 : word_addr_reg + 8'h01;
      end
    end
  end

  always_ff @(posedge SYS_CLK_IN) begin
    if (!RST_B_IN) begin
      ARRAY_ADDR_OUT <= 8'h00;
      ARRAY_RD_OUT <= 1'b0;
    end else begin
      ARRAY_ADDR_OUT <= word_addr_reg;
      // One pulse per byte handed to the shifter
      ARRAY_RD_OUT <= kind_reg == wp_pkg::CMD_ARRAY && scl_fall &&
        !start_seen && !stop_seen &&
        ((state_reg == wp_pkg::ST_DEV_ACK && rw_reg) ||
         (state_reg == wp_pkg::ST_MACK && master_ack_reg));
    end
  end

  // ************************************************************
  // Protect flag updates
  // ************************************************************
  always_ff @(posedge SYS_CLK_IN) begin
    if (!RST_B_IN || start_seen) begin
      pend_set_perm_reg <= 1'b0;
      pend_set_rev_reg <= 1'b0;
      pend_clr_rev_reg <= 1'b0;
    end else if (data_byte_done && kind_reg != wp_pkg::CMD_ARRAY) begin
      pend_set_perm_reg <= verdict.set_perm;
      pend_set_rev_reg <= verdict.set_rev;
      pend_clr_rev_reg <= verdict.clr_rev;
    end else if (stop_seen) begin
      pend_set_perm_reg <= 1'b0;
      pend_set_rev_reg <= 1'b0;
      pend_clr_rev_reg <= 1'b0;
    end
  end

  // Takes effect at the stop of a complete write; no reset on purpose
  always_ff @(posedge SYS_CLK_IN) begin
    if (stop_seen && data_seen_reg) begin
      if (pend_set_perm_reg) begin
        perm_flag_reg <= 1'b1;
      end
      if (pend_set_rev_reg) begin
        rev_flag_reg <= 1'b1;
      end else if (pend_clr_rev_reg && !perm_flag_reg) begin
        rev_flag_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge SYS_CLK_IN) begin
    if (!RST_B_IN) begin
      PERMANENT_PROTECT_FLAG_OUT <= 1'b0;
      REVERSIBLE_PROTECT_FLAG_OUT <= 1'b0;
    end else begin
      PERMANENT_PROTECT_FLAG_OUT <= perm_flag_reg;
      REVERSIBLE_PROTECT_FLAG_OUT <= rev_flag_reg;
    end
  end

  // ************************************************************
  // Register port
  // ************************************************************
  always_ff @(posedge SYS_CLK_IN) begin
    if (!RST_B_IN) begin
      ctrl_reg <= wp_pkg::CTRL_RESET;
    end else if (REG_WR_IN && REG_ADDR_IN == wp_pkg::REG_CTRL_OFS) begin
      ctrl_reg <= REG_WDATA_IN;
    end
  end

  always_ff @(posedge SYS_CLK_IN) begin
    if (!RST_B_IN) begin
      REG_RDATA_OUT <= 8'h00;
    end else if (REG_RD_IN) begin
      REG_RDATA_OUT <= 8'h00;
      if (REG_ADDR_IN == wp_pkg::REG_CTRL_OFS) begin
        REG_RDATA_OUT <= ctrl_reg;
      end else if (REG_ADDR_IN == wp_pkg::REG_STATUS_OFS) begin
        REG_RDATA_OUT[wp_pkg::ST_PERM_BIT] <= perm_flag_reg;
        REG_RDATA_OUT[wp_pkg::ST_REV_BIT] <= rev_flag_reg;
        REG_RDATA_OUT[wp_pkg::ST_WP_BIT] <= pins_s.wp;
        REG_RDATA_OUT[wp_pkg::ST_BUSY_BIT] <= state_reg != wp_pkg::ST_IDLE;
        REG_RDATA_OUT[wp_pkg::ST_REFUSED_BIT] <= refused_reg;
        REG_RDATA_OUT[wp_pkg::ST_HV_BIT] <= pins_s.hv;
      end else if (REG_ADDR_IN == wp_pkg::REG_ADDR_OFS) begin
        REG_RDATA_OUT <= word_addr_reg;
      end
    end
  end

endmodule

// >>> test/eeprom_wp_checker.sv
// Port assertions for the write-protect controller.
// Assumes WP only changes while the two-wire bus is idle.
`timescale 1ns/1ps
module eeprom_wp_checker (
  input wire logic SYS_CLK_IN,
  input wire logic RST_B_IN,
  input wire logic SCL_IN,
  input wire logic SDA_OE_OUT,
  input wire logic WP_IN,
  input wire logic ARRAY_WR_OUT,
  input wire logic [7:0] ARRAY_ADDR_OUT,
  input wire logic PERMANENT_PROTECT_FLAG_OUT,
  input wire logic REVERSIBLE_PROTECT_FLAG_OUT,
  input wire logic [3:0] REG_ADDR_IN,
  input wire logic REG_RD_IN,
  input wire logic [7:0] REG_RDATA_OUT
);
  logic [3:0] wp_cnt_reg;
  logic [3:0] scl_cnt_reg;
  logic wp_prev_reg;
  logic perm;
  logic rev;
  logic wp_hi;
  assign perm = PERMANENT_PROTECT_FLAG_OUT;
  assign rev = REVERSIBLE_PROTECT_FLAG_OUT;
  // WP is trusted only once it has outlived the synchroniser
  assign wp_hi = WP_IN && (wp_cnt_reg >= 4'h8);
  always_ff @(posedge SYS_CLK_IN) begin
    wp_prev_reg <= WP_IN;
    if (!RST_B_IN || WP_IN != wp_prev_reg) begin
      wp_cnt_reg <= 4'h0;
    end else if (wp_cnt_reg != 4'hF) begin
      wp_cnt_reg <= wp_cnt_reg + 4'h1;
    end
  end
  always_ff @(posedge SYS_CLK_IN) begin
    if (!RST_B_IN || !SCL_IN) begin
      scl_cnt_reg <= 4'h0;
    end else if (scl_cnt_reg != 4'hF) begin
      scl_cnt_reg <= scl_cnt_reg + 4'h1;
    end
  end
  default clocking @(posedge SYS_CLK_IN); endclocking
  default disable iff (!RST_B_IN);
  sequence status_rd_s;
    REG_RD_IN && REG_ADDR_IN == wp_pkg::REG_STATUS_OFS;
  endsequence
  sequence flags_seen_s;
    REG_RDATA_OUT[wp_pkg::ST_PERM_BIT] == perm &&
      REG_RDATA_OUT[wp_pkg::ST_REV_BIT] == rev;
  endsequence
  wr_low_half_a : assert property (
    ARRAY_WR_OUT && !ARRAY_ADDR_OUT[7] |-> !perm && !rev)
    else $error("write reached protected lower half");
  wr_pin_hi_a : assert property (wp_hi |-> !ARRAY_WR_OUT)
    else $error("array write while pin high");
  flag_pin_hi_a : assert property (
    wp_hi |-> $stable(perm) && $stable(rev))
    else $error("flag changed while pin high");
  perm_keep_a : assert property (perm |=> perm)
    else $error("permanent flag cleared");
  rev_keep_a : assert property (perm && rev |=> rev)
    else $error("reversible flag cleared under permanent");
  flag_rise_a : assert property (
    $rose(perm) || $rose(rev) |-> !WP_IN)
    else $error("flag set while pin high");
  oe_scl_hi_a : assert property (
    SCL_IN && scl_cnt_reg >= 4'h1 |-> $stable(SDA_OE_OUT))
    else $error("data drive changed while clock high");
  status_flags_a : assert property (status_rd_s |=> flags_seen_s)
    else $error("status shows wrong flags");
endmodule
bind eeprom_write_protect_control eeprom_wp_checker chk_i (.*);

// >>> test/bus_host.sv
// Two-wire bus host model, one command per call.
// Assumes an open-drain data line with a pull-up in the bench.
`timescale 1ns/1ps
module bus_host (
  input wire logic clk_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_low_out
);
  logic [7:0] rd_last = 8'h00;
  initial begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
  end
  task automatic w(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  // One 80 ns bit; data moves only while the clock is low
  task automatic bit_x(input logic b, output logic s);
    w(2);
    sda_low_out <= !b;
    w(2);
    scl_out <= 1'b1;
    w(2);
    @(negedge clk_in);
    s = sda_in;
    w(2);
    scl_out <= 1'b0;
  endtask
  task automatic byte_x(input logic [7:0] tx, output logic [7:0] rx,
                        output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) begin
      bit_x(tx[i], rx[i]);
    end
    bit_x(1'b1, a);
    ack = !a;
  endtask
  task automatic cmd(input logic [7:0] dev, word, dat, output logic ack);
    logic [7:0] r;
    logic a;
    w(2);
    sda_low_out <= 1'b0;
    w(2);
    scl_out <= 1'b1;
    w(2);
    sda_low_out <= 1'b1;
    w(2);
    scl_out <= 1'b0;
    byte_x(dev, r, ack);
    if (dev[0]) begin
      byte_x(8'hFF, rd_last, a);
    end else begin
      // Protected writes must still see every byte acknowledged
      byte_x(word, r, a);
      ack = ack && a;
      byte_x(dat, r, a);
      ack = ack && a;
    end
    w(2);
    sda_low_out <= 1'b1;
    w(2);
    scl_out <= 1'b1;
    w(2);
    sda_low_out <= 1'b0;
    w(4);
  endtask
endmodule

// >>> test/tb_top.sv
// Self-checking bench for the write-protect controller.
// Assumes bus_host as the far side and a pull-up on the data line.
`timescale 1ns/1ps
module tb_top;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic wp = 1'b0;
  logic hv = 1'b0;
  logic a1 = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [3:0] reg_a = 4'h0;
  logic [7:0] reg_d = 8'h00;
  logic [7:0] s;
  logic [7:0] last_a;
  logic [7:0] last_d;
  int fails = 0;
  int check_count = 0;
  int nwr = 0;
  int nrd = 0;
  wire scl, low, oe, wr_o, perm, rev, sdo, rd_o;
  wire [7:0] aadr, adat, rdat;
  wire sda = !(low || (oe && !sdo));
  always #5 clk = ~clk;
  always @(negedge clk) begin
    if (rd_o === 1'b1) begin
      nrd++;
    end
    if (wr_o === 1'b1) begin
      nwr++;
      last_a = aadr;
      last_d = adat;
    end
  end
  bus_host host (.clk_in(clk), .sda_in(sda), .scl_out(scl),
    .sda_low_out(low));
  eeprom_write_protect_control uut (.SYS_CLK_IN(clk), .RST_B_IN(rst_b),
    .SCL_IN(scl), .SDA_IN(sda), .SDA_OUT(sdo), .SDA_OE_OUT(oe), .WP_IN(wp),
    .ADDR_PIN_ZERO_IN(1'b0), .ADDR_PIN_ONE_IN(a1), .ADDR_PIN_TWO_IN(1'b0),
    .HIGH_VOLTAGE_LEVEL_IN(hv), .ARRAY_WR_OUT(wr_o), .ARRAY_ADDR_OUT(aadr),
    .ARRAY_WDATA_OUT(adat), .ARRAY_RD_OUT(rd_o), .ARRAY_RDATA_IN(~aadr),
    .PERMANENT_PROTECT_FLAG_OUT(perm), .REVERSIBLE_PROTECT_FLAG_OUT(rev),
    .REG_ADDR_IN(reg_a), .REG_WDATA_IN(reg_d), .REG_WR_IN(reg_wr),
    .REG_RD_IN(reg_rd), .REG_RDATA_OUT(rdat));
  task automatic chk(input logic [7:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic rg(input logic wr, input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= wr;
    reg_rd <= !wr;
    reg_a <= a;
    reg_d <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    @(negedge clk);
    s = rdat;
  endtask
  // Pins settle well before the next START
  task automatic pin(input logic [2:0] v);
    @(posedge clk);
    {wp, hv, a1} <= v;
    repeat (8) @(posedge clk);
  endtask
  task automatic go(input logic [7:0] dev, input logic exp,
                    input logic [7:0] word = 8'h00, dat = 8'h00);
    logic ack;
    int n;
    host.cmd(dev, word, dat, ack);
    chk({7'h00, ack}, {7'h00, exp});
    n = 0;
    do begin
      rg(1'b0, wp_pkg::REG_STATUS_OFS, 8'h00);
      n++;
    end while (s[wp_pkg::ST_BUSY_BIT] !== 1'b0 && n < 2000);
    if (n >= 2000) begin
      fails++;
      conclude();
    end
  endtask
  task automatic arr(input logic [7:0] a, d, input logic keep);
    int n0;
    n0 = nwr;
    go(8'hA0, 1'b1, a, d);
    chk(8'(nwr - n0), {7'h00, keep});
    if (keep) begin
      chk(last_a, a);
      chk(last_d, d);
    end
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    rg(1'b0, wp_pkg::REG_CTRL_OFS, 8'h00);
    chk(s, wp_pkg::CTRL_RESET);
    rg(1'b0, 4'hC, 8'h00);
    chk(s, 8'h00);
    arr(8'h10, 8'h5A, 1'b1);
    pin(3'h2);
    go(8'h63, 1'b1);
    pin(3'h0);
    go(8'h61, 1'b1);
    $display("test status reads finished");
    pin(3'h4);
    arr(8'h90, 8'h11, 1'b0);
    go(8'hA1, 1'b1);
    // Bench array returns the inverted address; counter sits at 91H
    chk(host.rd_last, 8'h6E);
    chk(8'(nrd), 8'h01);
    go(8'h60, 1'b1);
    chk({7'h00, perm}, 8'h00);
    pin(3'h6);
    go(8'h62, 1'b1);
    chk({7'h00, rev}, 8'h00);
    $display("test pin high finished");
    pin(3'h2);
    go(8'h62, 1'b1);
    chk({7'h00, rev}, 8'h01);
    chk({7'h00, s[wp_pkg::ST_REV_BIT]}, 8'h01);
    go(8'h63, 1'b0);
    go(8'h62, 1'b0);
    pin(3'h0);
    arr(8'h7F, 8'h22, 1'b0);
    chk({7'h00, s[wp_pkg::ST_REFUSED_BIT]}, 8'h01);
    arr(8'h80, 8'h33, 1'b1);
    pin(3'h3);
    go(8'h66, 1'b1);
    chk({7'h00, rev}, 8'h00);
    pin(3'h0);
    arr(8'h00, 8'h44, 1'b1);
    rg(1'b1, wp_pkg::REG_CTRL_OFS, 8'h00);
    go(8'hA0, 1'b0);
    rg(1'b1, wp_pkg::REG_CTRL_OFS, wp_pkg::CTRL_RESET);
    $display("test reversible finished");
    pin(3'h2);
    go(8'h62, 1'b1);
    pin(3'h0);
    go(8'h60, 1'b1);
    chk({7'h00, perm}, 8'h01);
    go(8'h61, 1'b0);
    go(8'h60, 1'b0);
    pin(3'h4);
    go(8'h61, 1'b0);
    pin(3'h3);
    go(8'h66, 1'b0);
    chk({7'h00, rev}, 8'h01);
    pin(3'h0);
    rst_b <= 1'b0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    chk({6'h00, perm, rev}, 8'h03);
    arr(8'h7F, 8'h55, 1'b0);
    arr(8'hFF, 8'h66, 1'b1);
    $display("test permanent finished");
    conclude();
  end
endmodule
